// [rtl/rcs_consts.svh]
// Offsets, field positions, reset values and timing counts of the reset cause block.
// How it works
// RQ1 - Power status holds two flags, bits 0-1.
// RQ2 - Without brown-out detect, bit 0 reads zero.
// RQ3 - Brown-out flag undefined after power-on; untouched.
// RQ4 - Brown-out reset clears brown-out flag only.
// RQ5 - Software arms brown-out flag, ignores it disabled.
// RQ6 - Power-on reset alone clears power-on flag.
// RQ7 - Software sets power-on flag after power-on.
// RQ8 - Crystal: 72 ms plus 1024 ticks, or ticks.
// RQ9 - Power-on sets expiry and power-down flags.
// RQ10 - Running master clear keeps core flags.
// RQ11 - Sleep master clear, irq wake: expiry 1, down 0.
// RQ12 - Irq wake with enable: next instruction, vector.
// RQ13 - Resistor-capacitor without delay: no time-out.
// RQ14 - Settle count 1024 ticks, crystal, power-on/wake.
// RQ15 - Low supply during delay restarts brown-out reset.
// RQ16 - Watchdog reset and wake update core flags.
// RQ17 - Resets load zero; wakes continue next instruction.
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH

`define RCS_ADDR_PWR_STATUS 5'h00
`define RCS_ADDR_CORE_STATUS 5'h04
`define RCS_ADDR_CONFIG 5'h08
`define RCS_ADDR_IRQ_STATUS 5'h0c
`define RCS_ADDR_IRQ_MASK 5'h10

`define RCS_PWR_BROWN_BIT 0
`define RCS_PWR_PWRON_BIT 1
`define RCS_CORE_DOWN_BIT 0
`define RCS_CORE_EXPIRY_BIT 1
`define RCS_CORE_HOLD_BIT 2

`define RCS_CFG_RESET 8'h08
`define RCS_IRQ_RESET_BIT 0
`define RCS_IRQ_WAKE_BIT 1
`define RCS_IRQ_DONE_BIT 2

`define RCS_CLK_HZ 10000000
`define RCS_PWRUP_MS 72
`define RCS_PWRUP_CYCLES (`RCS_PWRUP_MS * (`RCS_CLK_HZ / 1000))
`define RCS_SETTLE_TICKS 1024
`define RCS_IRQ_VECTOR 13'h0004

`endif

// [rtl/rcs_pkg.sv]
// Types shared by the reset cause and start-up time-out block.
`default_nettype none
package rcs_pkg;
  typedef enum logic [1:0] {
    crystal_mode,
    fast_crystal_mode,
    lowfreq_crystal_mode,
    resistor_capacitor_mode
  } rcs_osc_e;

  typedef enum logic [1:0] {
    RCS_RUN,
    RCS_PWRUP_WAIT,
    RCS_SETTLE_WAIT
  } rcs_state_e;

  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
  } rcs_av_req_s;

  typedef struct packed {
    logic pwron;
    logic brownout;
    logic master_clear;
    logic watchdog;
    logic irq_wake;
  } rcs_evt_s;
endpackage : rcs_pkg
`default_nettype wire

// [rtl/rcs_top.sv]
// Reset cause flags, start-up time-outs and program counter reload with an Avalon-MM slave.
//
// Register access over Avalon-MM and the register offsets were decided locally.
`include "rcs_consts.svh"
`default_nettype none
module rcs_top
  import rcs_pkg::*;
#(
  parameter bit HAS_BROWNOUT = 1'b1,
  parameter int PWRUP_CYCLES = `RCS_PWRUP_CYCLES,
  parameter int SETTLE_TICKS = `RCS_SETTLE_TICKS,
  parameter int PC_W = 13
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire rcs_av_req_s av_req_i,
  output logic [31:0] av_readdata_o,
  output logic av_waitrequest_o,
  input wire rcs_evt_s evt_i,
  input wire logic asleep_i,
  input wire logic supply_low_i,
  input wire logic osc_tick_i,
  input wire logic global_irq_enable_i,
  input wire logic instr_done_i,
  output logic core_hold_o,
  output logic pc_load_o,
  output logic [PC_W-1:0] pc_value_o,
  output logic resume_next_o,
  output logic irq_o
);

  localparam int CNT_W = $clog2(PWRUP_CYCLES + SETTLE_TICKS + 1);

  rcs_state_e state_r;
  logic [CNT_W-1:0] cnt_r;
  logic brownout_flag_n;
  logic pwron_flag_n;
  logic expiry_flag_n;
  logic powerdown_flag_n;
  logic [7:0] cfg_r;
  logic [2:0] irq_st_r;
  logic [2:0] irq_mask_r;
  logic ack_r;
  logic vec_pend_r;

  // Configuration fields.
  rcs_osc_e osc_mode;
  logic powerup_delay_enable_n;
  logic brownout_enable_cfg;
  assign osc_mode = rcs_osc_e'(cfg_r[1:0]);
  assign powerup_delay_enable_n = cfg_r[2];
  assign brownout_enable_cfg = cfg_r[3];

  logic xtal;
  logic brown_live;
  logic ev_pwron;
  logic ev_brown;
  logic ev_master_clear_n;
  logic ev_wdog;
  logic ev_iwake;
  logic any_reset;
  logic any_wake;
  logic timeout_done;

  assign xtal = (osc_mode != resistor_capacitor_mode);
  assign brown_live = HAS_BROWNOUT && brownout_enable_cfg;
  // One event is served per cycle, the most severe first.
  assign ev_pwron = evt_i.pwron;
  assign ev_brown = !ev_pwron && brown_live &&
                    (evt_i.brownout || (state_r == RCS_PWRUP_WAIT && supply_low_i)); // RQ15
  assign ev_master_clear_n = !ev_pwron && !ev_brown && evt_i.master_clear;
  assign ev_wdog = !ev_pwron && !ev_brown && !ev_master_clear_n && evt_i.watchdog;
  assign ev_iwake = !ev_pwron && !ev_brown && !ev_master_clear_n && !ev_wdog &&
                    evt_i.irq_wake && asleep_i;
  assign any_reset = ev_pwron || ev_brown || ev_master_clear_n || (ev_wdog && !asleep_i);
  assign any_wake = ev_iwake || (ev_wdog && asleep_i);

  // Bus handshake: one wait cycle, then the answer.
  logic req;
  logic wr_ok;
  assign req = av_req_i.read || av_req_i.write;
  assign av_waitrequest_o = req && !ack_r;
  assign wr_ok = av_req_i.write && ack_r;

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req && !ack_r;
    end
  end

  // Start-up time-out sequencer.
  rcs_state_e state_nxt;
  always_comb begin
    state_nxt = state_r;
    if (ev_pwron) begin
      if (!powerup_delay_enable_n) begin
        state_nxt = RCS_PWRUP_WAIT; // RQ8
      end else if (xtal) begin
        state_nxt = RCS_SETTLE_WAIT; // RQ8
      end else begin
        state_nxt = RCS_RUN; // RQ13
      end
    end else if (ev_brown) begin
      state_nxt = RCS_PWRUP_WAIT; // RQ8
    end else if (any_wake) begin
      state_nxt = xtal ? RCS_SETTLE_WAIT : RCS_RUN; // RQ14
    end else if (any_reset) begin
      state_nxt = RCS_RUN;
    end else if (state_r == RCS_PWRUP_WAIT && cnt_r == CNT_W'(PWRUP_CYCLES - 1)) begin
      state_nxt = xtal ? RCS_SETTLE_WAIT : RCS_RUN; // RQ14
    end else if (state_r == RCS_SETTLE_WAIT && osc_tick_i &&
                 cnt_r == CNT_W'(SETTLE_TICKS - 1)) begin
      state_nxt = RCS_RUN; // RQ14
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      state_r <= RCS_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Cycles in the power-up wait, oscillator ticks in the settle wait.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      cnt_r <= '0;
    end else if (state_nxt != state_r || ev_brown || ev_pwron || any_wake) begin
      cnt_r <= '0; // RQ15
    end else if (state_r == RCS_PWRUP_WAIT) begin
      cnt_r <= cnt_r + 1'b1; // RQ8
    end else if (state_r == RCS_SETTLE_WAIT && osc_tick_i) begin
      cnt_r <= cnt_r + 1'b1; // RQ14
    end
  end

  assign core_hold_o = (state_r != RCS_RUN);
  assign timeout_done = (state_r != RCS_RUN) && (state_nxt == RCS_RUN);

  // Power status flags; a hardware event wins over a software write.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      pwron_flag_n <= 1'b0;
    end else if (ev_pwron) begin
      pwron_flag_n <= 1'b0; // RQ6
    end else if (wr_ok && av_req_i.address == `RCS_ADDR_PWR_STATUS) begin
      pwron_flag_n <= av_req_i.writedata[`RCS_PWR_PWRON_BIT];
    end
  end

  // Power-on leaves this flag alone, so its value there is whatever it held.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      brownout_flag_n <= 1'b0;
    end else if (!HAS_BROWNOUT) begin
      brownout_flag_n <= 1'b0; // RQ2
    end else if (ev_brown) begin
      brownout_flag_n <= 1'b0; // RQ4
    end else if (!ev_pwron && wr_ok && av_req_i.address == `RCS_ADDR_PWR_STATUS) begin
      brownout_flag_n <= av_req_i.writedata[`RCS_PWR_BROWN_BIT]; // RQ3
    end
  end

  // Core status flags.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      expiry_flag_n <= 1'b1;
      powerdown_flag_n <= 1'b1;
    end else if (ev_pwron || ev_brown) begin
      expiry_flag_n <= 1'b1; // RQ9
      powerdown_flag_n <= 1'b1; // RQ9
    end else if ((ev_master_clear_n && asleep_i) || ev_iwake) begin
      expiry_flag_n <= 1'b1; // RQ11
      powerdown_flag_n <= 1'b0; // RQ11
    end else if (ev_wdog) begin
      expiry_flag_n <= 1'b0; // RQ16
      powerdown_flag_n <= !asleep_i; // RQ16
    end
  end

  // Program counter reload; a vectored wake first lets one instruction run.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      pc_load_o <= 1'b0;
      pc_value_o <= '0;
      resume_next_o <= 1'b0;
      vec_pend_r <= 1'b0;
    end else begin
      pc_load_o <= 1'b0;
      resume_next_o <= 1'b0;
      if (any_reset) begin
        pc_load_o <= 1'b1; // RQ17
        pc_value_o <= '0; // RQ17
        vec_pend_r <= 1'b0;
      end else if (any_wake) begin
        resume_next_o <= 1'b1; // RQ17
        vec_pend_r <= ev_iwake && global_irq_enable_i; // RQ12
      end else if (vec_pend_r && instr_done_i && !core_hold_o) begin
        pc_load_o <= 1'b1; // RQ12
        pc_value_o <= PC_W'(`RCS_IRQ_VECTOR); // RQ12
        vec_pend_r <= 1'b0;
      end
    end
  end

  // Configuration register.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      cfg_r <= `RCS_CFG_RESET;
    end else if (wr_ok && av_req_i.address == `RCS_ADDR_CONFIG) begin
      cfg_r <= {4'h0, av_req_i.writedata[3:0]};
    end
  end

  // Interrupt status is write-one-to-clear; a new event in the same cycle wins.
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  assign irq_set = {timeout_done, any_wake, any_reset};
  assign irq_clr = (wr_ok && av_req_i.address == `RCS_ADDR_IRQ_STATUS) ?
                   av_req_i.writedata[2:0] : 3'h0;

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      irq_st_r <= 3'h0;
      irq_mask_r <= 3'h0;
    end else begin
      irq_st_r <= (irq_st_r & ~irq_clr) | irq_set;
      if (wr_ok && av_req_i.address == `RCS_ADDR_IRQ_MASK) begin
        irq_mask_r <= av_req_i.writedata[2:0];
      end
    end
  end

  assign irq_o = |(irq_st_r & irq_mask_r);

  // Read data is captured in the wait cycle and stands while waitrequest is low.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (av_req_i.address)
      `RCS_ADDR_PWR_STATUS: begin
        rd_mux[`RCS_PWR_PWRON_BIT] = pwron_flag_n; // RQ1
        rd_mux[`RCS_PWR_BROWN_BIT] = HAS_BROWNOUT & brownout_flag_n; // RQ2
      end
      `RCS_ADDR_CORE_STATUS: begin
        rd_mux[`RCS_CORE_DOWN_BIT] = powerdown_flag_n;
        rd_mux[`RCS_CORE_EXPIRY_BIT] = expiry_flag_n;
        rd_mux[`RCS_CORE_HOLD_BIT] = core_hold_o;
      end
      `RCS_ADDR_CONFIG: rd_mux[7:0] = cfg_r;
      `RCS_ADDR_IRQ_STATUS: rd_mux[2:0] = irq_st_r;
      `RCS_ADDR_IRQ_MASK: rd_mux[2:0] = irq_mask_r;
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      av_readdata_o <= 32'h0;
    end else if (av_req_i.read && !ack_r) begin
      av_readdata_o <= rd_mux;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  pwron_clear_a: assert property (ev_pwron |=> !pwron_flag_n) // RQ6
    else $error("power-on flag not cleared");
  pwron_keep_a: assert property (!ev_pwron && !wr_ok |=> $stable(pwron_flag_n)) // RQ6
    else $error("power-on flag moved without cause");
  brown_clear_a: assert property (ev_brown |=> !brownout_flag_n) // RQ4
    else $error("brown-out flag not cleared");
  brown_absent_a: assert property (!HAS_BROWNOUT && av_req_i.read && ack_r &&
    av_req_i.address == `RCS_ADDR_PWR_STATUS |-> !av_readdata_o[`RCS_PWR_BROWN_BIT]) // RQ2
    else $error("absent brown-out bit reads one");
  pwron_core_a: assert property (ev_pwron |=> expiry_flag_n && powerdown_flag_n) // RQ9
    else $error("power-on did not set core flags");
  run_master_a: assert property (ev_master_clear_n && !asleep_i |=> $stable(expiry_flag_n)
    && $stable(powerdown_flag_n)) // RQ10
    else $error("running master clear changed core flags");
  sleep_wake_a: assert property ((ev_master_clear_n && asleep_i) || ev_iwake
    |=> expiry_flag_n && !powerdown_flag_n) // RQ11
    else $error("sleep wake flags wrong");
  wdog_flags_a: assert property (ev_wdog |=> !expiry_flag_n &&
    powerdown_flag_n == !$past(asleep_i)) // RQ16
    else $error("watchdog flags wrong");
  reset_pc_a: assert property (any_reset |=> pc_load_o && pc_value_o == '0) // RQ17
    else $error("reset did not load zero");
  rc_notimeout_a: assert property (ev_pwron && !xtal && powerup_delay_enable_n
    |=> !core_hold_o) // RQ13
    else $error("time-out in resistor-capacitor mode");
  settle_len_a: assert property (any_wake && xtal && !ev_pwron
    |=> core_hold_o [*8]) // RQ14
    else $error("settle wait ended too soon");
  vector_a: assert property (ev_iwake && global_irq_enable_i
    |=> resume_next_o && !pc_load_o) // RQ12
    else $error("vector before next instruction");
  restart_a: assert property (state_r == RCS_PWRUP_WAIT && supply_low_i && brown_live
    |=> state_r == RCS_PWRUP_WAIT && cnt_r == '0) // RQ15
    else $error("power-up delay not restarted");

endmodule : rcs_top
`default_nettype wire

// [verif/rcs_top_tb.sv]
// Self-checking bench for the reset cause and start-up time-out block.
`default_nettype none
module rcs_top_tb import rcs_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  // Short counts keep the run brief; the longer waits below are derived from them.
  localparam int PU = 20;
  localparam int ST = 8;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  rcs_av_req_s av_req = '0;
  rcs_evt_s evt = '0;
  logic asleep = 1'b0, sup_low = 1'b0, tick = 1'b0, global_irq_enable = 1'b0, idone = 1'b0;
  logic [31:0] rd, rd2, q, q2;
  logic wreq, wreq2, hold, pcl, resume, irq;
  logic [12:0] pcv;
  int mismatches = 0, n_compared = 0, cyc = 0, m_pwr = 0, m_exp = 1, m_down = 1;
  int seed = int'(32'h85643e8c);

  initial begin
    forever #50 mclk_i = ~mclk_i;
  end

  rcs_top #(.PWRUP_CYCLES(PU), .SETTLE_TICKS(ST)) DUT (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .av_req_i(av_req), .av_readdata_o(rd),
    .av_waitrequest_o(wreq), .evt_i(evt), .asleep_i(asleep), .supply_low_i(sup_low),
    .osc_tick_i(tick), .global_irq_enable_i(global_irq_enable), .instr_done_i(idone),
    .core_hold_o(hold), .pc_load_o(pcl), .pc_value_o(pcv), .resume_next_o(resume),
    .irq_o(irq));

  // A variant without brown-out detection shares every input with the first one.
  rcs_top #(.HAS_BROWNOUT(1'b0), .PWRUP_CYCLES(PU), .SETTLE_TICKS(ST)) DUT_nobo (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .av_req_i(av_req), .av_readdata_o(rd2),
    .av_waitrequest_o(wreq2), .evt_i(evt), .asleep_i(asleep), .supply_low_i(sup_low),
    .osc_tick_i(tick), .global_irq_enable_i(global_irq_enable), .instr_done_i(idone),
    .core_hold_o(), .pc_load_o(), .pc_value_o(), .resume_next_o(), .irq_o());

  task test_done;
    if (mismatches == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      test_done();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // The request stands until the rising edge that samples waitrequest low; data is taken there.
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    av_req <= '{read: ~wr, write: wr, address: a, writedata: d};
    do @(posedge mclk_i); while (wreq !== 1'b0);
    q = rd;
    q2 = rd2;
    av_req <= '0;
  endtask : bus

  task rd_chk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    chk(q, e);
  endtask : rd_chk

  // Events: 0 power-on, 1 brown-out, 2 master clear, 3 watchdog, 4 interrupt wake.
  task fire(input int k, input logic slp, input logic h);
    logic wake;
    wake = (k == 4) || (k == 3 && slp);
    @(posedge mclk_i);
    asleep <= slp;
    evt <= rcs_evt_s'(5'h10 >> k);
    @(posedge mclk_i);
    evt <= '0;
    asleep <= 1'b0;
    #1;
    case (k)
      0, 1: begin
        m_pwr &= (k == 0) ? 1 : 2;
        m_exp = 1;
        m_down = 1;
      end
      3: begin
        m_exp = 0;
        m_down = !slp;
      end
      default: if (k == 4 || slp) begin
        m_exp = 1;
        m_down = 0;
      end
    endcase
    chk(32'({pcl, resume}), wake ? 32'h1 : 32'h2);
    if (!wake) chk(32'(pcv), 32'h0);
    chk(32'(hold), 32'(h));
    rd_chk(5'h04, 32'({h, m_exp[0], m_down[0]}));
    rd_chk(5'h00, 32'(m_pwr));
  endtask : fire

  initial begin
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 6; i++) rd_chk(5'(4 * i), (i == 1) ? 32'h3 : (i == 2) ? 32'h8 : 32'h0);
    repeat (4) begin
      q = $random(seed);
      m_pwr = q[1:0];
      bus(1'b1, 5'h00, q);
      bus(1'b0, 5'h00, '0);
      chk(q, 32'(m_pwr));
      chk(q2, 32'(m_pwr & 2));
    end
    bus(1'b1, 5'h04, $random(seed));
    bus(1'b1, 5'h14, $random(seed));
    rd_chk(5'h04, 32'h3);
    bus(1'b1, 5'h10, 32'h4);
    bus(1'b1, 5'h00, 32'h3);
    m_pwr = 3;
    fire(0, 1'b0, 1'b1);
    repeat (PU + 4) @(posedge mclk_i);
    tick <= 1'b1;
    repeat (ST - 1) @(posedge mclk_i);
    tick <= 1'b0;
    repeat (3) @(posedge mclk_i);
    #1;
    chk(32'(hold), 32'h1);
    @(posedge mclk_i);
    tick <= 1'b1;
    @(posedge mclk_i);
    tick <= 1'b0;
    repeat (3) @(posedge mclk_i);
    #1;
    chk(32'({hold, irq}), 32'h1);
    rd_chk(5'h0c, 32'h5);
    bus(1'b1, 5'h0c, 32'h5);
    rd_chk(5'h0c, 32'h0);
    chk(32'(irq), 32'h0);
    bus(1'b1, 5'h00, 32'h3);
    m_pwr = 3;
    fire(1, 1'b0, 1'b1);
    tick <= 1'b1;
    repeat (8) @(posedge mclk_i);
    sup_low <= 1'b1;
    repeat (2) @(posedge mclk_i);
    sup_low <= 1'b0;
    repeat (PU - 4) @(posedge mclk_i);
    #1;
    chk(32'(hold), 32'h1);
    repeat (PU + ST) @(posedge mclk_i);
    #1;
    chk(32'(hold), 32'h0);
    @(posedge mclk_i);
    tick <= 1'b0;
    bus(1'b1, 5'h08, 32'hf);
    global_irq_enable <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      for (int s = 0; s < 2; s++) begin
        if ((k < 2 && s == 1) || (k == 4 && s == 0)) continue;
        fire(k, s[0], k == 1);
        if (k == 4) begin
          @(posedge mclk_i);
          idone <= 1'b1;
          @(posedge mclk_i);
          idone <= 1'b0;
          repeat (3) begin
            #1;
            if (pcl !== 1'b1) @(posedge mclk_i);
          end
          chk(32'({pcl, pcv}), 32'h2004);
        end
        repeat (PU + 4) @(posedge mclk_i);
      end
    end
    // A watchdog wake in crystal mode must hold the core for the settle count.
    bus(1'b1, 5'h08, 32'h8);
    fire(3, 1'b1, 1'b1);
    tick <= 1'b1;
    repeat (ST + 2) @(posedge mclk_i);
    #1;
    chk(32'(hold), 32'h0);
    test_done();
  end
endmodule : rcs_top_tb
`default_nettype wire
